// ### hw/ibc_loop_code.sv
// In-band loop code generator and detector with an AHB-Lite register slave.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Contract
// RL1: receive length field n selects n+1 bits
// RL2: transmit pattern register, left-justified, index 0x13
// RL3: bit 7 sent first, then lower bits
// RL4: loop-up pattern register at index 0x14
// RL5: loop-down pattern register at index 0x15
// RL6: compare only top L pattern bits
// RL7: bits 1 and 0 used only when long
// RL8: transmit field selects 5, 6, 7, 8 bits
// RL9: repeat pattern; F slot every 193 bits
// RL10: flag code after 48 ms present
// RL11: restart integration on any mismatching bit
module ibc_loop_code #(
    parameter int unsigned INTEG_CYCLES = ibc_pkg::INTEG_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic txBitStrobe,
    output logic txLoopBit,
    output logic txLoopDrive,
    input wire logic rxBitStrobe,
    input wire logic rxBit,
    output logic upCodePresent,
    output logic downCodePresent,
    output logic irq
);
    localparam int CW = $clog2(INTEG_CYCLES + 1);
    localparam logic [CW-1:0] CNT_MAX = CW'(INTEG_CYCLES);

    generate
        if (INTEG_CYCLES < 2) begin : g_bad_integ
            $error("INTEG_CYCLES must be at least 2");
        end
    endgenerate

    // True when the newest len bits of hist are some rotation of the
    // top len bits of pat; lower pattern bits never take part.
    function automatic logic ibcMatch(input logic [7:0] hist,
                                      input logic [7:0] pat,
                                      input logic [3:0] len);
        logic hit;
        logic ok;
        logic [4:0] idx;
        hit = 1'b0;
        ok = 1'b0;
        idx = 5'h00;
        for (int r = 0; r < 8; r++) begin
            ok = (4'(r) < len);
            for (int k = 0; k < 8; k++) begin
                idx = 5'(len) - 5'h01 - 5'(k) + 5'(r);
                if (idx >= 5'(len)) begin
                    idx = idx - 5'(len);
                end
                if (4'(k) < len && hist[k] != pat[3'h7 - idx[2:0]]) begin
                    ok = 1'b0;
                end
            end
            hit = hit | ok;
        end
        return hit;
    endfunction

    logic [7:0] lenCtrl_r;
    logic [7:0] txPat_r;
    logic [7:0] rxPat_r [2];
    logic [1:0] ctrl_r;
    logic [1:0] flags_r;
    logic [1:0] mask_r;
    logic wrPend_r;
    logic [7:0] wrIdx_r;
    logic [31:0] hrdata_r;
    logic addrPh;
    logic addrOk;
    logic [7:0] addrIdx;
    logic [7:0] rdVal;
    logic fwdHit;
    logic rdStatus;
    logic [3:0] txLen;
    logic [3:0] rxLen [2];
    ibc_pkg::ibc_txst_e txState_r;
    logic [3:0] txIdx_r;
    logic [7:0] frameCnt_r;
    logic txLoopBit_r;
    logic txLoopDrive_r;
    logic fSlot;
    logic [7:0] hist_r;
    logic [3:0] fill_r;
    logic [7:0] histNxt;
    logic [1:0] match_r;
    logic [CW-1:0] cnt_r [2];
    logic [1:0] codeEvt;
    logic [1:0] rxMiss;
    logic [1:0] present;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign addrPh = hsel && htrans[1] && hready;
    assign addrIdx = haddr[9:2];
    assign addrOk = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    assign rdStatus = addrPh && !hwrite && addrOk
                    && addrIdx == ibc_pkg::IDX_STATUS;

    // A write still in its data phase is forwarded to a read behind it.
    always_comb begin
        fwdHit = wrPend_r && wrIdx_r == addrIdx;
        rdVal = 8'h00;
        case (addrIdx)
            ibc_pkg::IDX_LEN_CTRL: rdVal = fwdHit ? hwdata[7:0] : lenCtrl_r;
            ibc_pkg::IDX_TX_PAT: rdVal = fwdHit ? hwdata[7:0] : txPat_r;
            ibc_pkg::IDX_UP_PAT: rdVal = fwdHit ? hwdata[7:0] : rxPat_r[0];
            ibc_pkg::IDX_DN_PAT: rdVal = fwdHit ? hwdata[7:0] : rxPat_r[1];
            ibc_pkg::IDX_CTRL: rdVal = {6'h00, fwdHit ? hwdata[1:0] : ctrl_r};
            ibc_pkg::IDX_STATUS: rdVal = {4'h0, present[0], present[1],
                                          flags_r};
            ibc_pkg::IDX_MASK: rdVal = {6'h00, fwdHit ? hwdata[1:0] : mask_r};
            default: rdVal = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wrPend_r <= 1'b0;
            wrIdx_r <= 8'h00;
            hrdata_r <= 32'h00000000;
        end else begin
            wrPend_r <= addrPh && hwrite && addrOk;
            wrIdx_r <= addrIdx;
            if (addrPh && !hwrite) begin
                hrdata_r <= {24'h000000, addrOk ? rdVal : 8'h00};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lenCtrl_r <= ibc_pkg::RST_LEN_CTRL;
            txPat_r <= ibc_pkg::RST_PAT;
            rxPat_r[0] <= ibc_pkg::RST_PAT;
            rxPat_r[1] <= ibc_pkg::RST_PAT;
            ctrl_r <= ibc_pkg::RST_CTRL;
            mask_r <= ibc_pkg::RST_FLAGS;
        end else if (wrPend_r) begin
            case (wrIdx_r)
                ibc_pkg::IDX_LEN_CTRL: lenCtrl_r <= hwdata[7:0];
                ibc_pkg::IDX_TX_PAT: txPat_r <= hwdata[7:0]; // see RL2
                ibc_pkg::IDX_UP_PAT: rxPat_r[0] <= hwdata[7:0]; // see RL4
                ibc_pkg::IDX_DN_PAT: rxPat_r[1] <= hwdata[7:0]; // see RL5
                ibc_pkg::IDX_CTRL: ctrl_r <= hwdata[1:0];
                ibc_pkg::IDX_MASK: mask_r <= hwdata[1:0];
                default: ;
            endcase
        end
    end

    // Index 0 of the receive arrays is the up code, index 1 the down code.
    assign txLen = ibc_pkg::TX_LEN_BASE
                 + {2'h0, lenCtrl_r[ibc_pkg::TXLEN_LSB +: 2]}; // see RL8
    assign rxLen[0] = {1'b0, lenCtrl_r[ibc_pkg::UPLEN_LSB +: 3]} + 4'h1; // see RL1
    assign rxLen[1] = {1'b0, lenCtrl_r[ibc_pkg::DNLEN_LSB +: 3]} + 4'h1; // see RL1

    // Transmit side: while sending, outputs change on a bit strobe and hold until the next; clearing send forces both low without one.
    assign fSlot = (frameCnt_r == 8'h00) && !ctrl_r[ibc_pkg::CTRL_FBIT_DIS];

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            txState_r <= ibc_pkg::IBC_TX_IDLE;
            txIdx_r <= 4'h0;
            frameCnt_r <= 8'h00;
            txLoopBit_r <= 1'b0;
            txLoopDrive_r <= 1'b0;
        end else begin
            case (txState_r)
                ibc_pkg::IBC_TX_IDLE: begin
                    txIdx_r <= 4'h0;
                    frameCnt_r <= 8'h00;
                    txLoopDrive_r <= 1'b0;
                    txLoopBit_r <= 1'b0;
                    if (ctrl_r[ibc_pkg::CTRL_SEND_EN]) begin
                        txState_r <= ibc_pkg::IBC_TX_SEND;
                    end
                end
                ibc_pkg::IBC_TX_SEND: begin
                    if (!ctrl_r[ibc_pkg::CTRL_SEND_EN]) begin
                        txState_r <= ibc_pkg::IBC_TX_IDLE;
                        txLoopDrive_r <= 1'b0;
                    end else if (txBitStrobe) begin
                        // The F slot overwrites a pattern bit; the pattern
                        // phase still advances, so the code stays periodic.
                        txLoopDrive_r <= !fSlot; // see RL9
                        txLoopBit_r <= fSlot ? 1'b0
                                     : txPat_r[3'h7 - txIdx_r[2:0]]; // see RL3
                        txIdx_r <= (txIdx_r + 4'h1 >= txLen) ? 4'h0
                                 : txIdx_r + 4'h1; // see RL8
                        frameCnt_r <= (frameCnt_r == ibc_pkg::FRAME_BITS - 8'h01)
                                    ? 8'h00 : frameCnt_r + 8'h01; // see RL9
                    end
                end
                default: txState_r <= ibc_pkg::IBC_TX_IDLE;
            endcase
        end
    end

    assign txLoopBit = txLoopBit_r;
    assign txLoopDrive = txLoopDrive_r;

    // Receive side: shared bit history, one integrator per code.
    assign histNxt = {hist_r[6:0], rxBit};

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hist_r <= 8'h00;
            fill_r <= 4'h0;
        end else if (rxBitStrobe) begin
            hist_r <= histNxt;
            if (fill_r != 4'h8) begin
                fill_r <= fill_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            match_r <= 2'h0;
            cnt_r[0] <= '0;
            cnt_r[1] <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (rxMiss[c]) begin
                    match_r[c] <= 1'b0;
                    cnt_r[c] <= '0; // see RL11
                end else begin
                    if (rxBitStrobe) begin
                        match_r[c] <= 1'b1;
                    end
                    if (match_r[c] && cnt_r[c] != CNT_MAX) begin
                        cnt_r[c] <= cnt_r[c] + CW'(1);
                    end
                end
            end
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_evt
        assign rxMiss[g] = rxBitStrobe && !(fill_r + 4'h1 >= rxLen[g]
            && ibcMatch(histNxt, rxPat_r[g], rxLen[g])); // see RL6, RL7
        assign codeEvt[g] = match_r[g] && !rxMiss[g]
                          && cnt_r[g] == CNT_MAX - CW'(1);
        assign present[g] = cnt_r[g] == CNT_MAX;
    end

    // A flag raised in the cycle its read clears it stays set.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flags_r <= ibc_pkg::RST_FLAGS;
        end else begin
            flags_r[ibc_pkg::ST_UP] <= codeEvt[0]
                || (flags_r[ibc_pkg::ST_UP] && !rdStatus); // see RL10
            flags_r[ibc_pkg::ST_DOWN] <= codeEvt[1]
                || (flags_r[ibc_pkg::ST_DOWN] && !rdStatus); // see RL10
        end
    end

    assign upCodePresent = present[0];
    assign downCodePresent = present[1];
    assign irq = |(flags_r & mask_r);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_wrReg(logic [7:0] ix);
        addrPh && hwrite && addrOk && addrIdx == ix ##1 1'b1;
    endsequence

    property p_txPatWr;
        s_wrReg(ibc_pkg::IDX_TX_PAT) |=> txPat_r == $past(hwdata[7:0]);
    endproperty
    a_txPatWr: assert property (p_txPatWr) else $error("tx pattern lost"); // see RL2

    property p_upPatWr;
        s_wrReg(ibc_pkg::IDX_UP_PAT) |=> rxPat_r[0] == $past(hwdata[7:0]);
    endproperty
    a_upPatWr: assert property (p_upPatWr) else $error("up pattern lost"); // see RL4

    property p_dnPatWr;
        s_wrReg(ibc_pkg::IDX_DN_PAT) |=> rxPat_r[1] == $past(hwdata[7:0]);
    endproperty
    a_dnPatWr: assert property (p_dnPatWr) else $error("down pattern lost"); // see RL5

    property p_rxLen;
        rxLen[0] - 4'h1 == {1'b0, lenCtrl_r[5:3]} && rxLen[0] != 4'h0;
    endproperty
    a_rxLen: assert property (p_rxLen) else $error("bad up length"); // see RL1

    property p_firstBit;
        txState_r == ibc_pkg::IBC_TX_SEND && ctrl_r[0] && txBitStrobe
            && txIdx_r == 4'h0 && !fSlot |=> txLoopBit_r == $past(txPat_r[7]);
    endproperty
    a_firstBit: assert property (p_firstBit) else $error("first bit not bit 7"); // see RL3

    property p_txIdx;
        txState_r == ibc_pkg::IBC_TX_SEND && ctrl_r[0] && txBitStrobe
            |=> txIdx_r < txLen;
    endproperty
    a_txIdx: assert property (p_txIdx) else $error("tx index out of range"); // see RL8

    property p_fSlot;
        txState_r == ibc_pkg::IBC_TX_SEND && ctrl_r[0] && txBitStrobe && fSlot
            |=> !txLoopDrive_r;
    endproperty
    a_fSlot: assert property (p_fSlot) else $error("F slot driven"); // see RL9

    property p_restart;
        rxMiss[0] |=> cnt_r[0] == '0 && !match_r[0];
    endproperty
    a_restart: assert property (p_restart) else $error("no restart"); // see RL11

    property p_upFlag;
        codeEvt[0] |=> flags_r[ibc_pkg::ST_UP];
    endproperty
    a_upFlag: assert property (p_upFlag) else $error("up flag not set"); // see RL10

    property p_irq;
        (flags_r & mask_r) != 2'h0 |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");
endmodule // ibc_loop_code

// ### pkg/ibc_pkg.sv
// Constants, field layout and types of the in-band loop code block.
package ibc_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_LEN_CTRL = 8'h12;
    localparam logic [7:0] IDX_TX_PAT = 8'h13;
    localparam logic [7:0] IDX_UP_PAT = 8'h14;
    localparam logic [7:0] IDX_DN_PAT = 8'h15;
    localparam logic [7:0] IDX_CTRL = 8'h20;
    localparam logic [7:0] IDX_STATUS = 8'h21;
    localparam logic [7:0] IDX_MASK = 8'h22;
    // Field positions inside code_length_ctrl.
    localparam int TXLEN_LSB = 6;
    localparam int UPLEN_LSB = 3;
    localparam int DNLEN_LSB = 0;
    // Control bits.
    localparam int CTRL_SEND_EN = 0;
    localparam int CTRL_FBIT_DIS = 1;
    // Status bits: sticky flags in 1:0, live presence in 3:2.
    localparam int ST_DOWN = 0;
    localparam int ST_UP = 1;
    localparam int ST_DOWN_LIVE = 2;
    localparam int ST_UP_LIVE = 3;
    // Values after reset.
    localparam logic [7:0] RST_LEN_CTRL = 8'h00;
    localparam logic [7:0] RST_PAT = 8'h00;
    localparam logic [1:0] RST_CTRL = 2'h0;
    localparam logic [1:0] RST_FLAGS = 2'h0;
    // Transmit length base and frame length in bits.
    localparam logic [3:0] TX_LEN_BASE = 4'h5;
    localparam logic [7:0] FRAME_BITS = 8'hc1;
    // Integration time of the code detector.
    localparam int INTEG_MS = 48;
    localparam int CLK_KHZ = 100000;
    localparam int INTEG_CYC = INTEG_MS * CLK_KHZ;
    typedef enum logic [0:0] {
        IBC_TX_IDLE = 1'b0,
        IBC_TX_SEND = 1'b1
    } ibc_txst_e;
endpackage

// ### tb/ibc_line_peer.sv
// Line-side peer model: bit strobes, a repeating receive code, transmit capture.
`timescale 1ns/100ps
module ibc_line_peer (
    input wire logic clk,
    input wire logic rxRun,
    input wire logic rxFlip,
    input wire logic [7:0] rxPat,
    input wire logic [3:0] rxLen,
    input wire logic txLoopBit,
    input wire logic txLoopDrive,
    output logic rxBitStrobe,
    output logic rxBit,
    output logic txBitStrobe
);
    logic [1:0] divCnt = 2'h0;
    logic [3:0] phase = 4'h0;
    initial begin
        rxBitStrobe = 1'b0;
        rxBit = 1'b0;
        txBitStrobe = 1'b0;
    end
    // Between strobes the data line carries nothing valid, so it toggles.
    always @(posedge clk) begin
        divCnt <= (divCnt == 2'h2) ? 2'h0 : divCnt + 2'h1;
        rxBitStrobe <= rxRun && divCnt == 2'h2;
        if (rxRun && divCnt == 2'h2) begin
            rxBit <= rxPat[3'h7 - phase[2:0]] ^ rxFlip;
            phase <= (phase + 4'h1 == rxLen) ? 4'h0 : phase + 4'h1;
        end else begin
            rxBit <= ~rxBit;
        end
        if (!rxRun) begin
            phase <= 4'h0;
        end
    end
    // One transmit bit slot; the answer is taken once it has settled.
    task automatic txStep(output logic b, output logic d);
        @(posedge clk);
        txBitStrobe <= 1'b1;
        @(posedge clk);
        txBitStrobe <= 1'b0;
        repeat (2) @(posedge clk);
        b = txLoopBit;
        d = txLoopDrive;
    endtask
endmodule // ibc_line_peer

// ### tb/tb_inband_loop_code_gen_detect.sv
// Testbench of the in-band loop code block: registers, transmit and detect.
`timescale 1ns/100ps
module tb_inband_loop_code_gen_detect;
    localparam int INTEG = 200;
    localparam logic [7:0] TXP = 8'hb5;
    logic clk, rst_b, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic txBitStrobe, txLoopBit, txLoopDrive, rxBitStrobe, rxBit;
    logic upCodePresent, downCodePresent, irq, rxRun, rxFlip, b, d;
    logic [7:0] rxPat;
    logic [3:0] rxLen;
    logic [7:0] idxTab [8] = '{ibc_pkg::IDX_LEN_CTRL, ibc_pkg::IDX_TX_PAT,
        ibc_pkg::IDX_UP_PAT, ibc_pkg::IDX_DN_PAT, ibc_pkg::IDX_CTRL,
        ibc_pkg::IDX_STATUS, ibc_pkg::IDX_MASK, 8'h16};
    logic [7:0] wrExp [8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'h00,
        8'h03, 8'h00};
    int fails = 0;
    int tests_run = 0;
    int n, len;
    assign hready = hreadyout;
    always #5 clk = ~clk;
    ibc_loop_code #(.INTEG_CYCLES(INTEG)) dut_u (.clk(clk), .rst_b(rst_b),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .txBitStrobe(txBitStrobe), .txLoopBit(txLoopBit),
        .txLoopDrive(txLoopDrive), .rxBitStrobe(rxBitStrobe), .rxBit(rxBit),
        .upCodePresent(upCodePresent), .downCodePresent(downCodePresent),
        .irq(irq));
    ibc_line_peer peer_u (.clk(clk), .rxRun(rxRun), .rxFlip(rxFlip),
        .rxPat(rxPat), .rxLen(rxLen), .txLoopBit(txLoopBit),
        .txLoopDrive(txLoopDrive), .rxBitStrobe(rxBitStrobe), .rxBit(rxBit),
        .txBitStrobe(txBitStrobe));
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic edgeWait(output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (k >= 50) begin
            chk("bus ready", 32'h1, 32'h0);
            test_done;
        end
    endtask
    // Every bus task starts and ends just after a rising edge.
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] wd, output logic [31:0] rdat);
        int k;
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        edgeWait(k);
        htrans <= 2'h0;
        hwdata <= wd;
        edgeWait(k);
        rdat = hrdata;
        chk("hresp", 32'h0, 32'(hresp));
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] x;
        xfer(1'b1, idx, wd, x);
    endtask
    task automatic rdChk(input string what, input logic [7:0] idx,
                         input logic [31:0] exp);
        logic [31:0] x;
        xfer(1'b0, idx, 32'h0, x);
        chk(what, exp, x);
    endtask
    task automatic doReset;
        rst_b <= 1'b0;
        rxRun <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
    endtask
    task automatic waitSig(input logic dn, input logic lvl, input int bound,
                           output int cnt);
        cnt = 0;
        while ((dn ? downCodePresent : upCodePresent) !== lvl
               && cnt < bound) begin
            @(posedge clk);
            cnt++;
        end
        if (cnt >= bound) begin
            chk("present wait", 32'(lvl), 32'(~lvl));
            test_done;
        end
    endtask
    // A one-bit error in the stream, held until the peer has sent it.
    // The peer must sample the flip request at a strobe edge, so one edge
    // passes before the strobe is looked for.
    task automatic flipBit;
        int k;
        k = 0;
        rxFlip <= 1'b1;
        @(posedge clk);
        do begin
            @(posedge clk);
            k++;
        end while (rxBitStrobe !== 1'b1 && k < 10);
        rxFlip <= 1'b0;
        if (k >= 10) begin
            chk("flip strobe", 32'h1, 32'h0);
            test_done;
        end
    endtask
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rxRun = 1'b0;
        rxFlip = 1'b0;
        rxPat = 8'h80;
        rxLen = 4'h1;
        doReset;
        for (int i = 0; i < 8; i++) wr(idxTab[i], 32'hffffffff);
        for (int i = 0; i < 8; i++) rdChk("reg", idxTab[i], 32'(wrExp[i]));
        doReset;
        for (int i = 0; i < 8; i++) rdChk("reg reset", idxTab[i], 32'h0);
        $display("register test done");
        for (int c = 0; c < 4; c++) begin
            len = 5 + c;
            wr(ibc_pkg::IDX_CTRL, 32'h0);
            wr(ibc_pkg::IDX_LEN_CTRL, 32'(c << ibc_pkg::TXLEN_LSB));
            wr(ibc_pkg::IDX_TX_PAT, 32'(TXP));
            wr(ibc_pkg::IDX_CTRL, 32'h1);
            repeat (2) @(posedge clk);
            for (int k = 0; k < 200; k++) begin
                peer_u.txStep(b, d);
                chk("tx drive", 32'(k % 193 != 0), 32'(d));
                if (k % 193 != 0) begin
                    chk("tx bit", 32'(TXP[7 - k % len]), 32'(b));
                end
            end
            $display("tx length %0d done", len);
        end
        wr(ibc_pkg::IDX_TX_PAT, 32'hff);
        wr(ibc_pkg::IDX_CTRL, 32'h3);
        for (int k = 0; k < 8; k++) begin
            peer_u.txStep(b, d);
            chk("tx unframed", 32'h3, {30'h0, d, b});
        end
        wr(ibc_pkg::IDX_CTRL, 32'h0);
        peer_u.txStep(b, d);
        chk("tx stop", 32'h0, 32'(d));
        for (int l = 1; l <= 8; l++) begin
            doReset;
            wr(ibc_pkg::IDX_LEN_CTRL, 32'(((l - 1) << ibc_pkg::UPLEN_LSB) | 7));
            wr(ibc_pkg::IDX_UP_PAT, 32'(8'h80 | (8'h7f >> (l - 1))));
            wr(ibc_pkg::IDX_DN_PAT, 32'hcc);
            wr(ibc_pkg::IDX_MASK, 32'h2);
            rxLen <= 4'(l);
            rxRun <= 1'b1;
            waitSig(1'b0, 1'b1, 400, n);
            chk("up delay", 32'h1, 32'(n >= INTEG && n <= INTEG + 40));
            chk("down present", 32'h0, 32'(downCodePresent));
            chk("irq", 32'h1, 32'(irq));
            flipBit;
            waitSig(1'b0, 1'b0, 10, n);
            rdChk("status", ibc_pkg::IDX_STATUS, 32'h2);
            chk("irq clear", 32'h0, 32'(irq));
            rdChk("status clear", ibc_pkg::IDX_STATUS, 32'h0);
            $display("up code length %0d done", l);
        end
        doReset;
        wr(ibc_pkg::IDX_LEN_CTRL, 32'((7 << ibc_pkg::UPLEN_LSB) | 3));
        wr(ibc_pkg::IDX_UP_PAT, 32'hcc);
        wr(ibc_pkg::IDX_DN_PAT, 32'h8f);
        rxLen <= 4'h4;
        rxRun <= 1'b1;
        waitSig(1'b1, 1'b1, 400, n);
        chk("down delay", 32'h1, 32'(n >= INTEG && n <= INTEG + 40));
        chk("up present", 32'h0, 32'(upCodePresent));
        chk("irq masked", 32'h0, 32'(irq));
        wr(ibc_pkg::IDX_MASK, 32'h1);
        @(posedge clk);
        chk("irq unmasked", 32'h1, 32'(irq));
        rdChk("status down", ibc_pkg::IDX_STATUS, 32'h5);
        chk("irq down clear", 32'h0, 32'(irq));
        $display("down code test done");
        test_done;
    end
endmodule // tb_inband_loop_code_gen_detect
